// ==== pkg/tws_pkg.sv ====
// constants shared by the two-wire eeprom slave and its bus master
// assumes a 250 MHz system clock on both ends
package tws_pkg;
    localparam int CLK_MHZ = 250;
    // spike rejection window in ns, longest glitch that is ignored
    localparam int SPIKE_REJECT_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_REJECT_NS * CLK_MHZ) / 1000;
    // maximum internal write cycle time in us
    localparam int WRITE_CYCLE_US = 1000;
    localparam int WRITE_CYC = WRITE_CYCLE_US * CLK_MHZ;
    // control byte layout
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int CS_MSB = 3;
    localparam int CS_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic DIR_READ = 1'h1;
    localparam logic DIR_WRITE = 1'h0;
    // page geometry
    localparam int PAGE_BITS = 4;
    localparam int PAGE_BYTES = 16;
    // serial clock quarter period of the master (one sequencing step), in system clocks
    localparam int MST_HALF_CYC = 8'h40;
    // reset values
    localparam logic [7:0] ADDR_RST = 8'h00;
endpackage

// ==== pkg/tws_if.sv ====
// two-wire bus between the eeprom slave and its master
// open-drain wires resolved here from the output enables, pulled high
`timescale 1ns/1ps
interface tws_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // wired-and with pull-up: any enabled low driver pulls the line low
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
        output sda_m_o, output sda_m_oe);
endinterface

// ==== design/tws_slave.sv ====
// two-wire eeprom slave front end: control byte decode, address pointer,
// 16-byte page buffer and self-timed write cycle with ack polling
// assumes the bus master drives scl; memory array sits on the user side
`timescale 1ns/1ps
module tws_slave #(
    parameter int WRITE_CYC = tws_pkg::WRITE_CYC,
    parameter logic [3:0] TYPE_CODE = 4'h5 // arbitrary type code value
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    tws_if.slave BUS,
    input wire logic CHIP_SELECT_STRAP_LOW_I,
    input wire logic CHIP_SELECT_STRAP_MID_I,
    input wire logic CHIP_SELECT_STRAP_HIGH_I,
    input wire logic SUPPLY_LOW_I,
    output logic WR_VALID_O,
    output logic [6:0] WR_ADDR_O,
    output logic [7:0] WR_DATA_O,
    output logic BUSY_O,
    output logic READ_REQ_O
);
    localparam int SPK = tws_pkg::SPIKE_CYC;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CTRL = 3'h1,
        ST_WADDR = 3'h2,
        ST_WDATA = 3'h3,
        ST_IGNORE = 3'h4,
        ST_FLUSH = 3'h5
    } tws_st_e;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] low_sync;
        logic [1:0][2:0] strap_sync;
        logic scl_f;
        logic sda_f;
        logic scl_prev;
        logic sda_prev;
        logic [4:0] scl_cnt;
        logic [4:0] sda_cnt;
        tws_st_e st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic ack_phase;
        logic ack_ok;
        logic sda_oe;
        logic [7:0] ptr;
        logic [3:0] base;
        logic [4:0] count;
        logic [15:0][7:0] page;
        logic [15:0] filled;
        logic wr_pend;
        logic [4:0] flush_i;
        logic [31:0] wcnt;
        logic busy;
        logic wr_valid;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic read_req;
    } tws_slv_s;

    tws_slv_s q, d;
    logic start_ev, stop_ev, rise_ev, fall_ev;
    logic [2:0] straps;

    assign straps = {CHIP_SELECT_STRAP_HIGH_I, CHIP_SELECT_STRAP_MID_I,
        CHIP_SELECT_STRAP_LOW_I};
    // bus condition detection on filtered lines
    assign start_ev = q.scl_f && q.scl_prev && q.sda_prev && !q.sda_f;
    assign stop_ev = q.scl_f && q.scl_prev && !q.sda_prev && q.sda_f;
    assign rise_ev = q.scl_f && !q.scl_prev;
    assign fall_ev = !q.scl_f && q.scl_prev;

    // all slave state in one step
    always_comb begin
        d = q;
        d.wr_valid = 1'h0;
        d.read_req = 1'h0;
        // two-flop synchronisers
        d.scl_sync = {q.scl_sync[0], BUS.scl};
        d.sda_sync = {q.sda_sync[0], BUS.sda};
        // supply detector and straps are pins too, same two-flop treatment
        d.low_sync = {q.low_sync[0], SUPPLY_LOW_I};
        d.strap_sync = {q.strap_sync[0], straps};
        // level must persist past spike window to be taken
        if (q.scl_sync[1] == q.scl_f) begin
            d.scl_cnt = 5'h00;
        end else if (q.scl_cnt >= 5'(SPK)) begin
            d.scl_f = q.scl_sync[1];
            d.scl_cnt = 5'h00;
        end else begin
            d.scl_cnt = q.scl_cnt + 5'h01;
        end
        if (q.sda_sync[1] == q.sda_f) begin
            d.sda_cnt = 5'h00;
        end else if (q.sda_cnt >= 5'(SPK)) begin
            d.sda_f = q.sda_sync[1];
            d.sda_cnt = 5'h00;
        end else begin
            d.sda_cnt = q.sda_cnt + 5'h01;
        end
        d.scl_prev = q.scl_f;
        d.sda_prev = q.sda_f;
        // self-timed write cycle counter
        if (q.busy) begin
            if (q.wcnt >= 32'(WRITE_CYC - 1)) begin
                d.busy = 1'h0;
                d.wcnt = 32'h0;
            end else begin
                d.wcnt = q.wcnt + 32'h1;
            end
        end
        if (start_ev) begin
            // start recognised in any state
            d.st = ST_CTRL;
            d.bitn = 4'h0;
            d.ack_phase = 1'h0;
            d.sda_oe = 1'h0;
            d.count = 5'h00;
            d.filled = 16'h0;
        end else if (stop_ev) begin
            // stop after buffered data launches commit unless supply is low
            d.sda_oe = 1'h0;
            d.st = ST_IDLE;
            if (q.st == ST_WDATA && q.filled != 16'h0 && !q.low_sync[1]) begin
                d.st = ST_FLUSH;
                d.flush_i = 5'h00;
                d.busy = 1'h1;
                d.wcnt = 32'h0;
            end
        end else if (q.st == ST_FLUSH) begin
            // hand buffered bytes to the array, page committed after stop
            if (q.flush_i[4] || q.low_sync[1]) begin
                d.st = ST_IDLE;
            end else begin
                if (q.filled[q.flush_i[3:0]]) begin
                    d.wr_valid = 1'h1;
                    d.wr_addr = {q.base[2:0], q.flush_i[3:0]};
                    d.wr_data = q.page[q.flush_i[3:0]];
                end
                d.flush_i = q.flush_i + 5'h01;
            end
        end else if (q.st != ST_IDLE && q.st != ST_IGNORE) begin
            if (rise_ev && !q.ack_phase) begin
                d.sh = {q.sh[6:0], q.sda_f};
                d.bitn = q.bitn + 4'h1;
            end
            if (fall_ev && q.ack_phase) begin
                // release after the ack clock; own nack leaves line high, rest of frame ignored
                d.sda_oe = 1'h0;
                d.ack_phase = 1'h0;
                if (!q.ack_ok) begin
                    d.st = ST_IGNORE;
                end
            end else if (fall_ev && q.bitn == 4'h8) begin
                d.bitn = 4'h0;
                d.ack_phase = 1'h1;
                d.ack_ok = 1'h0;
                case (q.st)
                    ST_CTRL: begin
                        // type and strap match, busy stays silent
                        if (q.sh[7:4] == TYPE_CODE
                            && q.sh[3:1] == q.strap_sync[1] && !q.busy) begin
                            d.ack_ok = 1'h1;
                            if (q.sh[0] == tws_pkg::DIR_READ) begin
                                d.read_req = 1'h1;
                                d.ack_ok = 1'h0;
                                d.sda_oe = 1'h1;
                                d.st = ST_IGNORE;
                            end else begin
                                d.st = ST_WADDR;
                            end
                        end
                    end
                    ST_WADDR: begin
                        d.ptr = {1'h0, q.sh[6:0]};
                        d.base = {1'h0, q.sh[6:4]};
                        d.ack_ok = 1'h1;
                        d.st = ST_WDATA;
                    end
                    ST_WDATA: begin
                        // only low four bits wrap within the page
                        d.page[q.ptr[3:0]] = q.sh;
                        d.filled[q.ptr[3:0]] = 1'h1;
                        d.ptr = {q.ptr[7:4], q.ptr[3:0] + 4'h1};
                        d.ack_ok = 1'h1;
                    end
                    default: begin
                        d.ack_ok = 1'h0;
                    end
                endcase
                // drive low over the whole ninth clock
                d.sda_oe = d.ack_ok || (d.read_req);
            end
        end
        // a read request answers with ack then releases; reads not served
        if (q.read_req) begin
            d.ack_phase = 1'h1;
            d.ack_ok = 1'h1;
            d.st = ST_CTRL;
        end
    end

    // state register
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            q <= '0;
            q.scl_sync <= 2'h3;
            q.sda_sync <= 2'h3;
            q.scl_f <= 1'h1;
            q.sda_f <= 1'h1;
            q.scl_prev <= 1'h1;
            q.sda_prev <= 1'h1;
            q.st <= ST_IDLE;
            q.ptr <= tws_pkg::ADDR_RST;
        end else begin
            q <= d;
        end
    end

    assign BUS.sda_s_o = 1'h0;
    assign BUS.sda_s_oe = q.sda_oe;
    assign WR_VALID_O = q.wr_valid;
    assign WR_ADDR_O = q.wr_addr;
    assign WR_DATA_O = q.wr_data;
    assign BUSY_O = q.busy;
    assign READ_REQ_O = q.read_req;
endmodule

// ==== design/tws_master.sv ====
// two-wire bus master: sends start, control byte, word address and data
// bytes, then stop; reports the ack seen after each byte
// assumes user holds the command fields stable while CMD_READY_O is low
`timescale 1ns/1ps
module tws_master #(
    parameter int HALF_CYC = tws_pkg::MST_HALF_CYC,
    parameter int MAX_BYTES = 18
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    tws_if.master BUS,
    input wire logic CMD_VALID_I,
    input wire logic [4:0] CMD_LEN_I,
    input wire logic [MAX_BYTES-1:0][7:0] CMD_BYTES_I,
    output logic CMD_READY_O,
    output logic DONE_O,
    output logic NACK_O
);
    typedef enum logic [2:0] {
        MS_IDLE = 3'h0,
        MS_START = 3'h1,
        MS_BIT = 3'h2,
        MS_ACK = 3'h3,
        MS_STOP = 3'h4,
        MS_END = 3'h5
    } tws_mst_e;

    typedef struct packed {
        tws_mst_e st;
        logic [1:0] sda_sync;
        logic [7:0] tick;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [4:0] idx;
        logic scl;
        logic sda;
        logic done;
        logic nack;
    } tws_mst_s;

    tws_mst_s q, d;
    logic step;

    assign step = q.tick >= 8'(HALF_CYC - 1);

    // bus sequencing in quarter phases of a bit
    always_comb begin
        d = q;
        d.done = 1'h0;
        d.sda_sync = {q.sda_sync[0], BUS.sda};
        d.tick = step ? 8'h00 : q.tick + 8'h01;
        case (q.st)
            MS_IDLE: begin
                d.tick = 8'h00;
                // begin only on idle bus
                if (CMD_VALID_I && q.sda_sync[1]) begin
                    d.st = MS_START;
                    d.idx = 5'h00;
                    d.ph = 2'h0;
                    d.nack = 1'h0;
                end
            end
            MS_START: begin
                // data falls while clock high, then clock low
                if (step) begin
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) d.sda = 1'h0;
                    if (q.ph == 2'h1) begin
                        d.scl = 1'h0;
                        d.st = MS_BIT;
                        d.bitn = 4'h0;
                        d.ph = 2'h0;
                    end
                end
            end
            MS_BIT, MS_ACK: begin
                // data set in clock low, sampled on high
                if (step) begin
                    d.ph = q.ph + 2'h1;
                    case (q.ph)
                        2'h0: d.sda = (q.st == MS_ACK) ? 1'h1 :
                            CMD_BYTES_I[q.idx][3'(7 - q.bitn)];
                        2'h1: d.scl = 1'h1;
                        2'h2: begin
                            if (q.st == MS_ACK && q.sda_sync[1]) begin
                                d.nack = 1'h1;
                            end
                        end
                        default: begin
                            d.scl = 1'h0;
                            if (q.st == MS_ACK) begin
                                d.idx = q.idx + 5'h01;
                                d.bitn = 4'h0;
                                d.st = (q.nack || q.idx + 5'h01 >= CMD_LEN_I)
                                    ? MS_STOP : MS_BIT;
                            end else if (q.bitn == 4'h7) begin
                                d.st = MS_ACK; // extra clock
                            end else begin
                                d.bitn = q.bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            MS_STOP: begin
                // data rises while clock high
                if (step) begin
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) d.sda = 1'h0;
                    if (q.ph == 2'h1) d.scl = 1'h1;
                    if (q.ph == 2'h2) begin
                        d.sda = 1'h1;
                        d.st = MS_END;
                    end
                end
            end
            MS_END: begin
                d.done = 1'h1;
                d.st = MS_IDLE;
            end
            default: d.st = MS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            q <= '0;
            q.sda_sync <= 2'h3;
            q.scl <= 1'h1;
            q.sda <= 1'h1;
            q.st <= MS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign BUS.scl_o = 1'h0;
    assign BUS.scl_oe = !q.scl;
    assign BUS.sda_m_o = 1'h0;
    assign BUS.sda_m_oe = !q.sda;
    assign CMD_READY_O = (q.st == MS_IDLE);
    assign DONE_O = q.done;
    assign NACK_O = q.nack;
endmodule

// ==== verification/tws_asserts.sv ====
// bus-level checks on the two-wire link between master and eeprom slave
// assumes the bench feeds the interface nets plus the shared clock/reset
`timescale 1ns/1ps
module tws_asserts (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic [7:0] cnt_q;
    logic [7:0] nrise;
    // rising scl edges since the last start or stop, this edge included
    assign nrise = cnt_q + {7'h00, scl & ~scl_q};
    // count clocks, cleared by any sda change while scl stays high
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            scl_q <= 1'h1;
            cnt_q <= 8'h00;
        end else begin
            scl_q <= scl;
            if (scl && scl_q && $changed(sda)) begin
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= nrise;
            end
        end
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    chk_slave_sda_hold: assert property (
        scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("slave sda moved while scl high");
    chk_master_sda_edges: assert property (
        scl && $past(scl) && $changed(sda_m_oe) |->
        (nrise == 8'h00 && sda_m_oe) || (nrise % 8'h09 == 8'h01 && !sda_m_oe))
        else $error("master sda moved while scl high");
    chk_start_then_clock: assert property (
        s_start |-> ##[1:64] !scl)
        else $error("no clock pulse after start");
    chk_stop_slave_quiet: assert property (
        s_stop |-> (!sda_s_oe) [*8])
        else $error("slave drove sda after stop");
    chk_bit_count: assert property (
        s_stop |-> nrise % 8'h09 == 8'h01)
        else $error("clock count not nine per byte");
    chk_ack_slot: assert property (
        sda_s_oe && scl |-> nrise % 8'h09 == 8'h00 && nrise != 8'h00)
        else $error("slave drove sda outside ack clock");
    chk_ack_low_high: assert property (
        $rose(scl) && sda_s_oe |-> (!sda) throughout (##[1:300] $fell(scl)))
        else $error("ack not low for whole high phase");
    chk_ack_release: assert property (
        $fell(scl) && nrise % 8'h09 == 8'h00 && nrise != 8'h00
        |-> ##[1:24] !sda_s_oe)
        else $error("slave kept sda after ack clock");
    // both lines high long enough for the slave filter to see an idle bus
    chk_start_bus_idle: assert property (
        s_start |-> $past(sda, 13) && $past(scl, 13))
        else $error("start without idle bus before it");
    // open-drain drivers may only ever pull their line low
    chk_drivers_pull_low: assert property (
        !(scl_oe && scl_o) && !(sda_m_oe && sda_m_o)
        && !(sda_s_oe && sda_s_o))
        else $error("open-drain driver drove a line high");
endmodule

// ==== verification/tb.sv ====
// self-checking bench: master and eeprom slave joined on one bus
// assumes package, interface and design files are compiled first
`timescale 1ns/1ps
module tb;
    localparam logic [3:0] TYPE = 4'h5; // arbitrary type code
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [2:0] strap = 3'h0;
    logic supply_low = 1'h0;
    logic cmd_valid = 1'h0;
    logic [4:0] cmd_len = 5'h01;
    logic [21:0][7:0] cmd_bytes = '0;
    logic [21:0][7:0] pkt = '0;
    logic cmd_ready, done, nack, wr_valid, busy, read_req;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [14:0] got_q[$];
    logic [14:0] exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int n_read = 0;
    tws_if bus();
    // 250 MHz system clock
    always #2 clk = ~clk;
    tws_slave #(.WRITE_CYC(2000), .TYPE_CODE(TYPE)) tws_slave_i (
        .CLOCK_I(clk), .RST_I(rst), .BUS(bus),
        .CHIP_SELECT_STRAP_LOW_I(strap[0]), .CHIP_SELECT_STRAP_MID_I(strap[1]),
        .CHIP_SELECT_STRAP_HIGH_I(strap[2]), .SUPPLY_LOW_I(supply_low),
        .WR_VALID_O(wr_valid), .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data),
        .BUSY_O(busy), .READ_REQ_O(read_req));
    // quarter bit of 12 cycles: the slave's 16-cycle filter lag must end
    // inside scl low, and the bus must idle 13+ cycles between frames
    tws_master #(.HALF_CYC(12), .MAX_BYTES(22)) tws_master_i (
        .CLOCK_I(clk), .RST_I(rst), .BUS(bus), .CMD_VALID_I(cmd_valid),
        .CMD_LEN_I(cmd_len), .CMD_BYTES_I(cmd_bytes),
        .CMD_READY_O(cmd_ready), .DONE_O(done), .NACK_O(nack));
    tws_asserts tws_asserts_i (
        .CLOCK_I(clk), .RST_I(rst), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
        .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe),
        .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe),
        .scl(bus.scl), .sda(bus.sda));
    // collect bytes handed to the array and read requests
    always @(posedge clk) begin
        if (wr_valid === 1'h1) got_q.push_back({wr_addr, wr_data});
        if (read_req === 1'h1) n_read++;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_wr(input logic [14:0] g, input logic [14:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp_wr({14'h0000, g}, {14'h0000, e});
    endtask
    // bounded wait for done (sel 0) or busy (sel 1)
    task automatic wait_hi(input bit sel, input int lim);
        int i;
        for (i = 0; i < lim && (sel ? busy : done) !== 1'h1; i++) @(posedge clk);
        if (i == lim) begin
            miscompares++;
            final_report();
        end
    endtask
    // hand pkt to the master, hold valid until taken, wait for done
    task automatic send(input int len);
        @(posedge clk);
        cmd_len <= 5'(len);
        cmd_bytes <= pkt;
        cmd_valid <= 1'h1;
        for (int i = 0; i < 100 && cmd_ready !== 1'h1; i++) @(posedge clk);
        @(posedge clk);
        cmd_valid <= 1'h0;
        wait_hi(1'b0, 16000);
    endtask
    // expected slots after a page write, last byte to a slot wins
    function automatic void expect_page(input int n);
        logic [7:0] pg[16];
        logic [15:0] fill;
        int s;
        fill = 16'h0000;
        for (int i = 0; i < n; i++) begin
            s = (pkt[1][3:0] + i) % 16;
            pg[s] = pkt[i + 2];
            fill[s] = 1'h1;
        end
        for (int k = 0; k < 16; k++)
            if (fill[k]) exp_q.push_back({pkt[1][6:4], 4'(k), pg[k]});
    endfunction
    // write n data bytes at a, poll for completion, check the commit
    task automatic page_write(input logic [7:0] a, input int n,
        input logic low);
        int tries;
        logic c;
        c = !low && n > 0;
        supply_low <= low;
        pkt[0] = {TYPE, strap, 1'h0};
        pkt[1] = a;
        for (int i = 0; i < n; i++) pkt[i + 2] = 8'($urandom);
        if (c) expect_page(n);
        send(n + 2);
        cmp1(nack, 1'h0);
        if (c) wait_hi(1'b1, 64);
        pkt[0] = {TYPE, strap, 1'h0};
        for (tries = 0; tries < 40; tries++) begin
            send(1);
            if (nack === 1'h0) break;
        end
        if (tries == 40) begin
            miscompares++;
            final_report();
        end
        if (!low) cmp1(tries > 0, c);
        cmp1(busy, 1'h0);
        cmp_wr(15'(got_q.size()), 15'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0)
            cmp_wr(got_q.pop_front(), exp_q.pop_front());
        got_q.delete();
        exp_q.delete();
    endtask
    // main sequence: reset, refused bytes, read, corner and random writes
    initial begin
        void'($urandom(16));
        strap <= 3'($urandom);
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (24) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            pkt[0] = k == 0 ? {TYPE ^ 4'h3, strap, 1'h0}
                : {TYPE, strap ^ 3'h1, 1'h0};
            send(1);
            cmp1(nack, 1'h1);
        end
        pkt[0] = {TYPE, strap, 1'h1};
        send(1);
        cmp1(nack, 1'h0);
        cmp_wr(15'(n_read), 15'h0001);
        page_write(8'h00, 1, 1'h0);
        page_write(8'h8D, 16, 1'h0);
        page_write(8'h7F, 16, 1'h0);
        page_write(8'h23, 20, 1'h0);
        page_write(8'h45, 0, 1'h0);
        page_write(8'h22, 3, 1'h1);
        repeat (3) page_write(8'($urandom), $urandom_range(1, 16), 1'h0);
        final_report();
    end
endmodule
